// ### rtl/scf_monitor.sv
// fault timing and qualification logic of the signal conflict monitor
module scf_monitor
    import scf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire scf_pins_type pins_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic relay_o,
    output logic fault_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        scf_pins_type s1;
        scf_pins_type s2;
        scf_pins_type s3;
        scf_pins_type f;
        logic wd_prev;
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic [NCH-1:0][9:0] rq_cnt;
        logic [NCH-1:0][9:0] yq_cnt;
        logic [NCH-1:0][9:0] gq_cnt;
        logic [9:0] sf1_cnt;
        logic [9:0] sf2_cnt;
        logic [9:0] cab_cnt;
        logic [10:0] wdt_cnt;
        logic [10:0] bo_cnt;
        logic bo;
        logic [NCH-1:0][10:0] rf_cnt;
        logic [NCH-1:0][11:0] yel_cnt;
        logic [NCH-1:0] armed;
        logic [NCH-1:0] rf_ch;
        logic [NCH-1:0] clr_ch;
        logic [NFLT-1:0] fault;
        scf_cfg_type cfg;
        logic [NCH-1:0] red_en;
        logic [NCH-1:0] clr_en;
        logic [NCH-1:0] yinh;
        logic [NFLT-1:0] irq_stat;
        logic [NFLT-1:0] irq_mask;
        logic [31:0] dat;
        logic ack;
        logic irq;
        logic relay;
        logic fault_any;
    } scf_state_type;

    scf_state_type st;
    scf_state_type nx;

    // saturating duration counter, cleared at once when the input drops
    function automatic logic [9:0] qual_cnt(input logic [9:0] c,
                                            input logic in,
                                            input logic tick,
                                            input logic [9:0] lim);
        if (!in) begin
            qual_cnt = '0;
        end else if (tick && c < lim) begin
            qual_cnt = c + 10'h001;
        end else begin
            qual_cnt = c;
        end
    endfunction

    function automatic logic [31:0] wr32(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        wr32 = (old & ~m) | (val & m);
    endfunction

    logic relay_act;
    logic sf_act;
    logic rf_gate;
    logic clr_gate;
    logic rst_cmd;
    logic pwr_evt;
    logic wdt_trip;
    logic cable_gone;
    logic req;
    logic wr;
    logic [10:0] rf_lim;
    logic [10:0] wdt_lim;
    logic [10:0] bo_lim;
    logic [NCH-1:0] red_q;
    logic [NCH-1:0] yel_q;
    logic [NCH-1:0] grn_q;
    logic [NCH-1:0] rf_hit;
    logic [NCH-1:0] clr_hit;
    logic [NFLT-1:0] hits;
    logic [NFLT-1:0] fclr;
    logic [NFLT-1:0] w1c;
    logic [31:0] wreg;

    always_comb begin
        nx = st;
        red_q = '0;
        yel_q = '0;
        grn_q = '0;
        rf_hit = '0;
        clr_hit = '0;
        w1c = '0;
        wreg = '0;
        // three-stage synchroniser; a change counts when stages 2 and 3 agree
        nx.s1 = pins_i;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        nx.f = scf_pins_type'((st.s3 & ~(st.s2 ^ st.s3))
                              | (st.f & (st.s2 ^ st.s3)));
        // millisecond time base shared by every duration counter
        nx.tick = 1'b0;
        if (st.tick_cnt == TICK_LAST) begin
            nx.tick_cnt = '0;
            nx.tick = 1'b1;
        end else begin
            nx.tick_cnt = st.tick_cnt + TW'(1);
        end

        relay_act = st.f.relay_common_sense ^ st.cfg.relay_pol;
        nx.sf1_cnt = qual_cnt(st.sf1_cnt, st.f.sf1, st.tick,
                              SF_QUAL_MS);
        nx.sf2_cnt = qual_cnt(st.sf2_cnt, st.f.sf2, st.tick,
                              SF_QUAL_MS);
        sf_act = (st.sf1_cnt == SF_QUAL_MS)
                 || (st.sf2_cnt == SF_QUAL_MS);
        rf_gate = st.f.red_enable && !sf_act && !relay_act;
        clr_gate = st.f.red_enable && !relay_act;
        rf_lim = st.cfg.ctrl_type ? RF_B_MS : RF_A_MS;
        wdt_lim = st.cfg.wdt_sel ? WDT_FAST_MS : WDT_SLOW_MS;
        bo_lim = st.cfg.bo_sel ? BO_LONG_MS : BO_SHORT_MS;

        // register bus: one cycle to ack, write lands with the ack
        req = wb_cyc_i && wb_stb_i && !st.ack;
        wr = req && wb_we_i;
        nx.ack = req;
        rst_cmd = st.f.panel_reset || st.f.remote_reset
                  || (wr && wb_adr_i == REG_CTRL && wb_sel_i[1]
                      && wb_dat_i[CTRL_RST_BIT]);

        // brown-out: low line must persist for the selected time
        if (!st.f.ac_low) begin
            nx.bo_cnt = '0;
        end else if (st.tick && st.bo_cnt < bo_lim) begin
            nx.bo_cnt = st.bo_cnt + 11'h001;
        end
        nx.bo = st.f.ac_low && (st.bo_cnt >= bo_lim);
        pwr_evt = st.f.power_fail || st.bo;

        // watchdog: any edge restarts the period; held at zero during power events
        nx.wd_prev = st.f.watchdog;
        if ((st.f.watchdog ^ st.wd_prev) || pwr_evt) begin
            nx.wdt_cnt = '0;
        end else if (st.tick && st.wdt_cnt < wdt_lim) begin
            nx.wdt_cnt = st.wdt_cnt + 11'h001;
        end
        wdt_trip = st.wdt_cnt >= wdt_lim;

        // cable detect is debounced so a reset glitch cannot latch a fault
        nx.cab_cnt = qual_cnt(st.cab_cnt, !st.f.red_interface_cable,
                              st.tick, QUAL_MS);
        cable_gone = st.cab_cnt == QUAL_MS;

        for (int i = 0; i < NCH; i++) begin
            nx.rq_cnt[i] = qual_cnt(st.rq_cnt[i], st.f.red[i], st.tick,
                                    QUAL_MS);
            nx.yq_cnt[i] = qual_cnt(st.yq_cnt[i], st.f.yel[i], st.tick,
                                    QUAL_MS);
            nx.gq_cnt[i] = qual_cnt(st.gq_cnt[i], st.f.grn[i], st.tick,
                                    QUAL_MS);
            red_q[i] = st.rq_cnt[i] == QUAL_MS;
            yel_q[i] = st.yq_cnt[i] == QUAL_MS;
            grn_q[i] = st.gq_cnt[i] == QUAL_MS;

            // absence of any qualified indication
            if (!rf_gate || !st.red_en[i] || red_q[i] || yel_q[i]
                || grn_q[i]) begin
                nx.rf_cnt[i] = '0;
            end else if (st.tick && st.rf_cnt[i] < rf_lim) begin
                nx.rf_cnt[i] = st.rf_cnt[i] + 11'h001;
            end
            rf_hit[i] = rf_gate && st.red_en[i]
                        && st.rf_cnt[i] >= rf_lim;

            // clearance: yellow time after green, judged when red arrives
            if (grn_q[i]) begin
                nx.armed[i] = 1'b1;
                nx.yel_cnt[i] = '0;
            end else if (st.armed[i]) begin
                if (yel_q[i] && st.tick && st.yel_cnt[i] < CLR_MS) begin
                    nx.yel_cnt[i] = st.yel_cnt[i] + 12'h001;
                end
                if (red_q[i]) begin
                    nx.armed[i] = 1'b0;
                    clr_hit[i] = st.yel_cnt[i] < CLR_MS && st.clr_en[i]
                                 && !st.yinh[i] && clr_gate;
                end
            end
        end

        hits = '0;
        hits[F_WDT] = wdt_trip;
        hits[F_CABLE] = cable_gone;
        hits[F_RED] = |rf_hit;
        hits[F_CLR] = |clr_hit;
        fclr = rst_cmd ? '1 : '0;
        if (pwr_evt && !st.cfg.wdt_latch) begin
            fclr[F_WDT] = 1'b1;
        end
        // a fault still present wins over the clearing command
        nx.fault = (st.fault & ~fclr) | hits;
        nx.fault[F_BO] = st.bo;
        nx.rf_ch = (rst_cmd ? '0 : st.rf_ch) | rf_hit;
        nx.clr_ch = (rst_cmd ? '0 : st.clr_ch) | clr_hit;

        // register writes
        if (wr) begin
            wreg = wr32(32'h00000000, wb_dat_i, wb_sel_i);
            unique case (wb_adr_i)
                REG_CTRL: nx.cfg = scf_cfg_type'(5'(
                    wr32({27'h0000000, st.cfg}, wb_dat_i, wb_sel_i)));
                REG_RED_EN: nx.red_en = NCH'(wr32({14'h0000, st.red_en},
                                                  wb_dat_i, wb_sel_i));
                REG_CLR_EN: nx.clr_en = NCH'(wr32({14'h0000, st.clr_en},
                                                  wb_dat_i, wb_sel_i));
                REG_YEL_INH: nx.yinh = NCH'(wr32({14'h0000, st.yinh},
                                                 wb_dat_i, wb_sel_i));
                REG_IRQ_STAT: w1c = wreg[NFLT-1:0];
                REG_IRQ_MASK: nx.irq_mask = NFLT'(wr32({27'h0000000,
                                              st.irq_mask}, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
        // new faults and brown-out onset raise sticky bits; set beats clear
        nx.irq_stat = (st.irq_stat & ~w1c) | (nx.fault & ~st.fault);
        nx.irq = |(nx.irq_stat & nx.irq_mask);
        // relay stays energised only while nothing is wrong
        nx.relay = ~|nx.fault;
        nx.fault_any = |nx.fault;

        nx.dat = '0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_CTRL: nx.dat = {27'h0000000, st.cfg};
                REG_RED_EN: nx.dat = {14'h0000, st.red_en};
                REG_CLR_EN: nx.dat = {14'h0000, st.clr_en};
                REG_YEL_INH: nx.dat = {14'h0000, st.yinh};
                REG_FAULT: nx.dat = {26'h0000000, st.relay, st.fault};
                REG_IRQ_STAT: nx.dat = {27'h0000000, st.irq_stat};
                REG_IRQ_MASK: nx.dat = {27'h0000000, st.irq_mask};
                REG_RF_CH: nx.dat = {14'h0000, st.rf_ch};
                REG_CLR_CH: nx.dat = {14'h0000, st.clr_ch};
                default: nx.dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign irq_o = st.irq;
    assign relay_o = st.relay;
    assign fault_o = st.fault_any;

    // relay and fault outputs are registered from the same next state
    relay_drop_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|st.fault) |-> !relay_o && fault_o)
        else $error("relay energised while a fault is held");
    fault_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.fault[F_RED] && !rst_cmd) |=> st.fault[F_RED])
        else $error("red failure dropped without reset");
    wdt_latch_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.fault[F_WDT] && st.cfg.wdt_latch && !rst_cmd)
        |=> st.fault[F_WDT])
        else $error("latched watchdog fault lost");
    wdt_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.fault[F_WDT] && !st.cfg.wdt_latch && pwr_evt && !wdt_trip)
        |=> !st.fault[F_WDT])
        else $error("watchdog fault kept across power event");
    wdt_early_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!st.fault[F_WDT] && st.wdt_cnt < wdt_lim) |=> !st.fault[F_WDT])
        else $error("watchdog fault before its period");
    bo_early_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.f.ac_low && st.bo_cnt < bo_lim) |=> !st.bo)
        else $error("brown-out declared before its time");
    rf_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rf_gate |=> (st.rf_cnt == '0))
        else $error("red failure timed while gated off");
    rf_chan_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(st.rf_ch[0]) |-> $past(st.red_en[0]))
        else $error("red failure on disabled channel");
    rf_trip_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|rf_hit) |=> st.fault[F_RED] && !relay_o)
        else $error("red failure not latched");
    clr_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(st.clr_ch[2])
        |-> $past(st.clr_en[2] && !st.yinh[2] && clr_gate))
        else $error("clearance fault while suppressed");
    clr_trip_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.armed[2] && red_q[2] && !grn_q[2] && st.yel_cnt[2] < CLR_MS
         && st.clr_en[2] && !st.yinh[2] && clr_gate)
        |=> st.fault[F_CLR] && st.clr_ch[2])
        else $error("short yellow not flagged");
    red_qual_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(red_q[0]) |-> $past(st.f.red[0]) && $past(st.tick))
        else $error("red qualified without a high input");
    sf_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!st.f.sf1 && !st.f.sf2) |=> !sf_act)
        else $error("override active without a high input");
    cable_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cable_gone |=> st.fault[F_CABLE] && !relay_o)
        else $error("cable removal not latched");
    sf_mask_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sf_act |=> (st.rf_cnt == '0)
                   && ((st.rf_ch & ~$past(st.rf_ch)) == '0))
        else $error("red failure timed under an override");
    irq_level_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_o == (|(st.irq_stat & st.irq_mask)))
        else $error("interrupt line disagrees with status");
    bus_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a one-cycle pulse");
endmodule // scf_monitor

// ### rtl/scf_pkg.sv
// constants, types and register map of the signal conflict fault timer
// How it works
// - watchdog period 1.0 s selected, else 1.5 s
// - brown-out after 400 ms or 80 ms low line
// - unlatched watchdog fault clears on power event
// - latched watchdog fault clears only on reset
// - jumper inverts relay common sense active level
// - unplugged red cable latches fault, forces flash
// - either override input suppresses red failure only
// - override active after 550 ms high
// - red on after 500 ms continuous high
// - green or yellow on after 500 ms high
// - faults except brown-out and unlatched watchdog latch until panel, remote or register reset
// - red failure after no indication, type timed
// - per-channel enable for red failure monitoring
// - red failure needs enable, no override, relay inactive
// - yellow under 2.7 s after green faults
// - per-channel enable for clearance monitoring
// - clearance suppressed by inhibit, enable, relay common
package scf_pkg;
    localparam int NCH = 18;
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYC = MS_NS / CLK_NS;
    // all timings below are in milliseconds of the tick
    localparam logic [10:0] WDT_FAST_MS = 11'h3E8;
    localparam logic [10:0] WDT_SLOW_MS = 11'h5DC;
    localparam logic [10:0] BO_LONG_MS = 11'h190;
    localparam logic [10:0] BO_SHORT_MS = 11'h050;
    localparam logic [9:0] QUAL_MS = 10'h1F4;
    localparam logic [9:0] SF_QUAL_MS = 10'h226;
    localparam logic [10:0] RF_A_MS = 11'h352;
    localparam logic [10:0] RF_B_MS = 11'h546;
    localparam logic [11:0] CLR_MS = 12'hA8C;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RED_EN = 8'h04;
    localparam logic [7:0] REG_CLR_EN = 8'h08;
    localparam logic [7:0] REG_YEL_INH = 8'h0C;
    localparam logic [7:0] REG_FAULT = 8'h10;
    localparam logic [7:0] REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam logic [7:0] REG_RF_CH = 8'h1C;
    localparam logic [7:0] REG_CLR_CH = 8'h20;
    localparam int CTRL_RST_BIT = 8;
    localparam int RELAY_BIT = 5;
    // fault and interrupt bit positions
    localparam int F_WDT = 0;
    localparam int F_BO = 1;
    localparam int F_CABLE = 2;
    localparam int F_RED = 3;
    localparam int F_CLR = 4;
    localparam int NFLT = 5;

    typedef struct packed {
        logic [NCH-1:0] red;
        logic [NCH-1:0] yel;
        logic [NCH-1:0] grn;
        logic sf1;
        logic sf2;
        logic red_enable;
        logic relay_common_sense;
        logic red_interface_cable;
        logic watchdog;
        logic ac_low;
        logic power_fail;
        logic panel_reset;
        logic remote_reset;
    } scf_pins_type;

    typedef struct packed {
        logic ctrl_type;
        logic relay_pol;
        logic wdt_latch;
        logic bo_sel;
        logic wdt_sel;
    } scf_cfg_type;
endpackage

// ### tb/scf_ctrl_model.sv
// controller model that toggles the watchdog line while it runs
module scf_ctrl_model
    import scf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int HALF_MS = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic watchdog_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt_r;
    // a stopped controller freezes the line at its last level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 0;
            watchdog_o <= 1'b0;
        end else if (run_i) begin
            if (cnt_r == TICK_CYCLES * HALF_MS - 1) begin
                cnt_r <= 0;
                watchdog_o <= ~watchdog_o;
            end else begin
                cnt_r <= cnt_r + 1;
            end
        end
    end
endmodule // scf_ctrl_model

// ### tb/scf_monitor_tb.sv
// self-checking bench of the signal conflict fault timer
module scf_monitor_tb
    import scf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // short tick keeps second-long timings inside the run budget
    localparam int TK = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    scf_pins_type p, pw;
    logic wd, run, cyc, stb, we, ack, irq, relay, fault;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, q;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk_i = ~clk_i;
    always_comb begin
        pw = p;
        pw.watchdog = wd;
    end
    scf_ctrl_model #(.TICK_CYCLES(TK)) ctl (.clk_i(clk_i), .rst_i(rst_i),
        .run_i(run), .watchdog_o(wd));
    scf_monitor #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .pins_i(pw), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .irq_o(irq), .relay_o(relay), .fault_o(fault));
    task automatic results;
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            results();
        end
    end
    task automatic ms(input int n);
        repeat (n * TK) @(posedge clk_i);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(n, e, q & m);
    endtask
    task automatic pulse_panel;
        p.red_enable <= 1'b0;
        p.panel_reset <= 1'b1;
        ms(5);
        p.panel_reset <= 1'b0;
        ms(5);
    endtask
    task automatic t_regs;
        rchk("ctrl rst", REG_CTRL, '1, 32'h0);
        rchk("fault rst", REG_FAULT, '1, 32'h20);
        xfer(1'b1, REG_CTRL, 32'h11F);
        rchk("ctrl", REG_CTRL, '1, 32'h1F);
        xfer(1'b1, REG_RED_EN, '1);
        rchk("red_en", REG_RED_EN, '1, 32'h3FFFF);
        xfer(1'b1, 8'h40, '1);
        rchk("unmapped", 8'h40, '1, 32'h0);
        xfer(1'b1, REG_FAULT, '1);
        rchk("fault ro", REG_FAULT, '1, 32'h20);
        xfer(1'b1, REG_CTRL, 32'h0);
        xfer(1'b1, REG_RED_EN, 32'h0);
    endtask
    task automatic t_wdt;
        xfer(1'b1, REG_IRQ_MASK, 32'h1);
        xfer(1'b1, REG_CTRL, 32'h1);
        run <= 1'b0;
        ms(900);
        rchk("wdt fast early", REG_FAULT, 32'h1, 32'h0);
        ms(200);
        rchk("wdt fast", REG_FAULT, 32'h1, 32'h1);
        chk("irq_o", 32'h1, {31'h0, irq});
        chk("relay_o", 32'h0, {31'h0, relay});
        chk("fault_o", 32'h1, {31'h0, fault});
        xfer(1'b1, REG_IRQ_STAT, 32'h1);
        ms(1);
        chk("irq_o clr", 32'h0, {31'h0, irq});
        run <= 1'b1;
        ms(100);
        p.power_fail <= 1'b1;
        ms(10);
        p.power_fail <= 1'b0;
        ms(10);
        rchk("wdt unlatched", REG_FAULT, 32'h1, 32'h0);
        xfer(1'b1, REG_CTRL, 32'h0);
        run <= 1'b0;
        ms(1400);
        rchk("wdt slow early", REG_FAULT, 32'h1, 32'h0);
        ms(200);
        rchk("wdt slow", REG_FAULT, 32'h1, 32'h1);
        xfer(1'b1, REG_CTRL, 32'h4);
        run <= 1'b1;
        ms(100);
        p.power_fail <= 1'b1;
        ms(10);
        p.power_fail <= 1'b0;
        ms(10);
        rchk("wdt latched", REG_FAULT, 32'h1, 32'h1);
        xfer(1'b1, REG_CTRL, 32'h104);
        ms(5);
        rchk("wdt reset cmd", REG_FAULT, 32'h1, 32'h0);
        xfer(1'b1, REG_CTRL, 32'h0);
        xfer(1'b1, REG_IRQ_STAT, '1);
        xfer(1'b1, REG_IRQ_MASK, 32'h0);
    endtask
    task automatic t_bo;
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, REG_CTRL, {30'h0, i[0], 1'b0});
            p.ac_low <= 1'b1;
            ms(i ? 350 : 60);
            rchk("bo early", REG_FAULT, 32'h2, 32'h0);
            ms(100);
            rchk("bo", REG_FAULT, 32'h2, 32'h2);
            chk("relay_o bo", 32'h0, {31'h0, relay});
            p.ac_low <= 1'b0;
            ms(5);
            rchk("bo gone", REG_FAULT, 32'h2, 32'h0);
        end
        xfer(1'b1, REG_CTRL, 32'h0);
    endtask
    task automatic t_cable;
        p.red_interface_cable <= 1'b0;
        ms(600);
        rchk("cable", REG_FAULT, 32'h4, 32'h4);
        chk("relay_o cable", 32'h0, {31'h0, relay});
        p.red_interface_cable <= 1'b1;
        ms(20);
        rchk("cable held", REG_FAULT, 32'h4, 32'h4);
        p.remote_reset <= 1'b1;
        ms(5);
        p.remote_reset <= 1'b0;
        ms(5);
        rchk("remote reset", REG_FAULT, '1, 32'h20);
    endtask
    // ch0 monitored, ch1 dark all run but not enabled
    task automatic t_red;
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, REG_CTRL, i ? 32'h10 : 32'h0);
            xfer(1'b1, REG_RED_EN, 32'h1);
            p.red[0] <= 1'b1;
            ms(5);
            p.red_enable <= 1'b1;
            ms(700);
            p.red[0] <= 1'b0;
            ms(i ? 1150 : 650);
            rchk("rf early", REG_FAULT, 32'h8, 32'h0);
            ms(400);
            rchk("rf", REG_FAULT, 32'h8, 32'h8);
            rchk("rf ch", REG_RF_CH, '1, 32'h1);
            chk("fault_o rf", 32'h1, {31'h0, fault});
            pulse_panel();
            rchk("rf cleared", REG_FAULT, '1, 32'h20);
        end
        xfer(1'b1, REG_CTRL, 32'h0);
    endtask
    // gates: no enable, override 1, override 2, sense high, inverted
    task automatic t_gate;
        for (int k = 0; k < 5; k++) begin
            xfer(1'b1, REG_CTRL, (k == 4) ? 32'h8 : 32'h0);
            xfer(1'b1, REG_RED_EN, 32'h1);
            p.sf1 <= (k == 1);
            p.sf2 <= (k == 2);
            p.relay_common_sense <= (k == 3);
            p.red[0] <= 1'b1;
            ms(5);
            p.red_enable <= (k != 0);
            ms(700);
            p.red[0] <= 1'b0;
            ms(1100);
            rchk("rf gated", REG_FAULT, 32'h8, 32'h0);
            p.sf1 <= 1'b0;
            p.sf2 <= 1'b0;
            p.relay_common_sense <= 1'b0;
            pulse_panel();
        end
        xfer(1'b1, REG_CTRL, 32'h0);
        xfer(1'b1, REG_RED_EN, 32'h0);
    endtask
    task automatic seq(input int y, input logic [NCH-1:0] m);
        p.red_enable <= 1'b1;
        p.grn <= m;
        ms(700);
        p.grn <= '0;
        p.yel <= m;
        ms(y);
        p.yel <= '0;
        p.red <= m;
        ms(700);
    endtask
    // yellow counts only once qualified, i.e. 500 ms after it rises
    task automatic t_clr;
        xfer(1'b1, REG_CLR_EN, 32'hC);
        xfer(1'b1, REG_YEL_INH, 32'h8);
        seq(3000, 18'h1C);
        rchk("clr short", REG_FAULT, 32'h10, 32'h10);
        rchk("clr ch", REG_CLR_CH, '1, 32'h4);
        p.red <= '0;
        pulse_panel();
        seq(3400, 18'h4);
        rchk("clr ok", REG_FAULT, 32'h10, 32'h0);
    endtask
    initial begin
        p = '0;
        p.red_interface_cable = 1'b1;
        run = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_wdt();
        t_bo();
        t_cable();
        t_red();
        t_gate();
        t_clr();
        results();
    end
endmodule // scf_monitor_tb
